// >>> verilog/mmr_mii_port.sv
// mac side mii port: rx/tx nibble paths, mdc/mdio engine, boot rom pin sharing
// assumes mii link clocks slow enough to be sampled by clk (bench uses 2.5 MHz)
// How it works
// - mdc is made from clk by a divider and never runs faster than 2.5 MHz.
// - mdio is shared, the port drives it in turn with the phy during read turnaround.
// - receive nibbles are taken synchronous to rxclk with rxd[3] as msb.
// - during a boot rom access the shared rx and tx pins carry rom address bits 15 to 6.
// - the phy receive output enable is held low for the whole boot rom access.
// - transmit nibbles change only on txclk rising edges with txd[3] as msb.
// - txen is updated on txclk and is high exactly while txd holds frame data.
// - mii outputs stay released unless the external phy is selected or a boot rom access is running.
// - line speed follows the forced setting or else the auto-negotiation result.
`timescale 1ns/10ps
`default_nettype none
module mmr_mii_port
  import mmr_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input wire logic externalPhySelect,
  input wire logic forceSpeed,
  input wire logic forcedSpeed100,
  input wire logic autoNegDone,
  input wire logic autoNegSpeed100,
  output logic lineSpeed100,
  // boot rom sharing
  input wire logic romAccess,
  input wire logic [15:6] bootRomAddress,
  // mii pins
  input wire logic colPin,
  input wire logic crsPin,
  input wire logic rxClkPin,
  input wire logic txClkPin,
  input wire mmr_rx_s rxPinIn,
  output mmr_rx_s rxPinOut,
  output logic rxPinOe,
  output logic phyReceiveOutputEnable,
  output logic phyReceiveOutputEnableOe,
  output logic [3:0] txdPin,
  output logic txEnPin,
  output logic txPinOe,
  output logic mdcPin,
  output logic mdcPinOe,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  // user receive side
  output mmr_rx_s rxData,
  output logic rxStrobe,
  output logic collision,
  output logic carrierSense,
  // user transmit side
  input wire mmr_tx_s txData,
  output logic txTaken,
  // user management side
  input wire logic mgmtStart,
  input wire mmr_mgmt_s mgmtReq,
  output logic mgmtBusy,
  output logic mgmtDone,
  output logic [15:0] mgmtReadData
);
  function automatic logic rose(input logic newer, input logic older);
    rose = newer && !older;
  endfunction : rose

  // three flop synchronisers; stage 0 feeds stage 1 only
  logic [SYNC_DEPTH-1:0] rxClkS, txClkS, colS, crsS, mdioS;
  mmr_rx_s rxS0, rxS1, rxS2;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxClkS <= '0;
      txClkS <= '0;
      colS <= '0;
      crsS <= '0;
      mdioS <= '0;
      rxS0 <= '0;
      rxS1 <= '0;
      rxS2 <= '0;
    end else begin
      rxClkS <= {rxClkS[SYNC_DEPTH-2:0], rxClkPin};
      txClkS <= {txClkS[SYNC_DEPTH-2:0], txClkPin};
      colS <= {colS[SYNC_DEPTH-2:0], colPin};
      crsS <= {crsS[SYNC_DEPTH-2:0], crsPin};
      mdioS <= {mdioS[SYNC_DEPTH-2:0], mdioIn};
      rxS0 <= rxPinIn;
      rxS1 <= rxS0;
      rxS2 <= rxS1;
    end
  end

  logic rxRise, txRise;
  assign rxRise = rose(rxClkS[1], rxClkS[2]);
  assign txRise = rose(txClkS[1], txClkS[2]);
  // col and crs are levels, taken once stages 1 and 2 agree
  logic collision_reg, crsSense_reg;
  assign collision = (colS[1] == colS[2]) ? colS[2] : collision_reg;
  assign carrierSense = (crsS[1] == crsS[2]) ? crsS[2] : crsSense_reg;

  // receive capture and transmit launch
  mmr_rx_s rxData_reg, rxData_next;
  logic rxStrobe_reg, rxStrobe_next;
  logic [3:0] txd_reg, txd_next;
  logic txEn_reg, txEn_next;
  logic lineSpeed100_reg, lineSpeed100_next;
  always_comb begin
    rxData_next = rxData_reg;
    rxStrobe_next = 1'b0;
    txd_next = txd_reg;
    txEn_next = txEn_reg;
    lineSpeed100_next = lineSpeed100_reg;
    if (rxRise && !romAccess) begin
      rxData_next = rxS2;
      rxStrobe_next = 1'b1;
    end
    if (txRise) begin
      txEn_next = txData.valid && !romAccess;
      txd_next = txEn_next ? txData.nibble : '0;
    end
    if (forceSpeed) begin
      lineSpeed100_next = forcedSpeed100;
    end else if (autoNegDone) begin
      lineSpeed100_next = autoNegSpeed100;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxData_reg <= '0;
      rxStrobe_reg <= 1'b0;
      txd_reg <= '0;
      txEn_reg <= 1'b0;
      lineSpeed100_reg <= 1'b0;
      collision_reg <= 1'b0;
      crsSense_reg <= 1'b0;
    end else begin
      rxData_reg <= rxData_next;
      rxStrobe_reg <= rxStrobe_next;
      txd_reg <= txd_next;
      txEn_reg <= txEn_next;
      lineSpeed100_reg <= lineSpeed100_next;
      collision_reg <= collision;
      crsSense_reg <= carrierSense;
    end
  end
  assign rxData = rxData_reg;
  assign rxStrobe = rxStrobe_reg;
  assign txTaken = txRise && txData.valid && !romAccess;
  assign lineSpeed100 = lineSpeed100_reg;

  // management engine: mdc divider and frame shifter
  mmr_mgmt_e mgState_reg, mgState_next;
  logic [2:0] div_reg, div_next;
  logic mdc_reg, mdc_next;
  logic [5:0] bit_reg, bit_next;
  logic [63:0] frame_reg, frame_next;
  logic isWrite_reg, isWrite_next;
  logic [15:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic mdcTick;
  assign mdcTick = (div_reg == MDC_DIV_LAST);
  always_comb begin
    mgState_next = mgState_reg;
    div_next = div_reg;
    mdc_next = mdc_reg;
    bit_next = bit_reg;
    frame_next = frame_reg;
    isWrite_next = isWrite_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    unique case (mgState_reg)
      MG_IDLE: begin
        div_next = '0;
        mdc_next = 1'b0;
        if (mgmtStart) begin
          mgState_next = MG_SHIFT;
          bit_next = '0;
          isWrite_next = mgmtReq.write;
          frame_next = {MG_PREAMBLE, MG_START, mgmtReq.write ? MG_OP_WRITE : MG_OP_READ,
                        mgmtReq.phyAddr, mgmtReq.regAddr,
                        mgmtReq.write ? MG_TA_WRITE : MG_TA_READ, mgmtReq.data};
        end
      end
      MG_SHIFT: begin
        div_next = mdcTick ? '0 : div_reg + 3'h1;
        if (mdcTick) begin
          mdc_next = !mdc_reg;
          if (!mdc_reg && !isWrite_reg && bit_reg >= MG_READ_DATA_FIRST) begin
            rdata_next = {rdata_reg[14:0], mdioS[2]};
          end
          if (mdc_reg) begin
            if (bit_reg == MG_LAST_BIT) begin
              mgState_next = MG_IDLE;
              done_next = 1'b1;
            end else begin
              bit_next = bit_reg + 6'h1;
              frame_next = {frame_reg[62:0], 1'b0};
            end
          end
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mgState_reg <= MG_IDLE;
      div_reg <= '0;
      mdc_reg <= 1'b0;
      bit_reg <= '0;
      frame_reg <= '0;
      isWrite_reg <= 1'b0;
      rdata_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      mgState_reg <= mgState_next;
      div_reg <= div_next;
      mdc_reg <= mdc_next;
      bit_reg <= bit_next;
      frame_reg <= frame_next;
      isWrite_reg <= isWrite_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
    end
  end
  assign mgmtBusy = (mgState_reg == MG_SHIFT);
  assign mgmtDone = done_reg;
  assign mgmtReadData = rdata_reg;
  // pin drivers: rom address takes over shared pins, otherwise mii needs external phy
  logic miiOn;
  assign miiOn = externalPhySelect && !romAccess;
  assign rxPinOut = romAccess ? {bootRomAddress[ROM_RXDV_BIT], bootRomAddress[ROM_RXER_BIT],
                                 bootRomAddress[ROM_RXD_LSB+3:ROM_RXD_LSB]} : '0;
  assign rxPinOe = romAccess;
  assign phyReceiveOutputEnable = !romAccess;
  assign phyReceiveOutputEnableOe = externalPhySelect || romAccess;
  assign txdPin = romAccess ? bootRomAddress[ROM_TXD_LSB+3:ROM_TXD_LSB] : txd_reg;
  assign txEnPin = txEn_reg && !romAccess;
  assign txPinOe = externalPhySelect || romAccess;
  assign mdcPin = mdc_reg;
  assign mdcPinOe = miiOn;
  assign mdioOut = frame_reg[63];
  assign mdioOe = miiOn && mgmtBusy && (isWrite_reg || bit_reg < MG_READ_RELEASE);

  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_mdcHalf;
    $rose(mdc_reg) |-> mdc_reg [*4] ##1 !mdc_reg;
  endproperty
  a_mdcHalf: assert property (p_mdcHalf) else $error("mdc high time wrong");
  property p_mdcLow;
    $fell(mdc_reg) && mgmtBusy |-> !mdc_reg [*4];
  endproperty
  a_mdcLow: assert property (p_mdcLow) else $error("mdc low time too short");
  property p_mdioTurn;
    mgmtBusy && !isWrite_reg && bit_reg >= MG_READ_RELEASE |-> !mdioOe;
  endproperty
  a_mdioTurn: assert property (p_mdioTurn) else $error("mdio driven during read");
  property p_romAddr;
    romAccess |-> rxPinOe && txdPin == bootRomAddress[15:12]
      && rxPinOut.dv == bootRomAddress[11] && rxPinOut.er == bootRomAddress[10];
  endproperty
  a_romAddr: assert property (p_romAddr) else $error("rom address not on pins");
  property p_phy_receive_output_enable;
    romAccess |-> !phyReceiveOutputEnable && !txEnPin && !mdioOe;
  endproperty
  a_phy_receive_output_enable: assert property (p_phy_receive_output_enable) else $error("phy not silenced in rom access");
  property p_txStable;
    !txRise |=> $stable(txd_reg) && $stable(txEn_reg);
  endproperty
  a_txStable: assert property (p_txStable) else $error("tx changed off txclk");
  property p_txEn;
    txRise && txData.valid && !romAccess |=> txEn_reg && txd_reg == $past(txData.nibble);
  endproperty
  a_txEn: assert property (p_txEn) else $error("txen or txd missed");
  property p_tristate;
    !externalPhySelect && !romAccess |-> !txPinOe && !mdcPinOe && !mdioOe && !rxPinOe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("mii driven without phy");
  property p_speed;
    forceSpeed |=> lineSpeed100 == $past(forcedSpeed100);
  endproperty
  a_speed: assert property (p_speed) else $error("forced speed ignored");
  property p_rxCap;
    rxRise && !romAccess |=> rxStrobe && rxData == $past(rxS2);
  endproperty
  a_rxCap: assert property (p_rxCap) else $error("rx nibble not captured");
  c_rxFrame: cover property (rxStrobe && rxData.dv);
  c_tx: cover property (txTaken);
  c_read: cover property (mgmtDone && !isWrite_reg);
  c_rom: cover property (romAccess && externalPhySelect);
endmodule : mmr_mii_port
`default_nettype wire

// >>> verilog/mmr_pkg.sv
// shared constants and carriers for the mii port with boot rom pin sharing
// assumes a 20 MHz system clock and an external phy on the mii pins
package mmr_pkg;
  // system clock and management clock limits
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MDC_MAX_HZ = 2_500_000;
  // half period of mdc in system clocks, rounded up so mdc never exceeds its limit
  localparam int unsigned MDC_HALF_CYCLES = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam logic [2:0] MDC_DIV_LAST = 3'(MDC_HALF_CYCLES - 1);
  // management frame layout, msb first
  localparam logic [5:0] MG_LAST_BIT = 6'h3F;
  localparam logic [5:0] MG_READ_RELEASE = 6'h2E;
  localparam logic [5:0] MG_READ_DATA_FIRST = 6'h30;
  localparam logic [31:0] MG_PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0] MG_START = 2'h1;
  localparam logic [1:0] MG_OP_WRITE = 2'h1;
  localparam logic [1:0] MG_OP_READ = 2'h2;
  localparam logic [1:0] MG_TA_WRITE = 2'h2;
  localparam logic [1:0] MG_TA_READ = 2'h3;
  // boot rom address bits carried on shared pins
  localparam int unsigned ROM_RXD_LSB = 6;
  localparam int unsigned ROM_RXER_BIT = 10;
  localparam int unsigned ROM_RXDV_BIT = 11;
  localparam int unsigned ROM_TXD_LSB = 12;
  // pin synchroniser depth
  localparam int unsigned SYNC_DEPTH = 3;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] nibble;
  } mmr_rx_s;

  typedef struct packed {
    logic valid;
    logic [3:0] nibble;
  } mmr_tx_s;

  typedef struct packed {
    logic write;
    logic [4:0] phyAddr;
    logic [4:0] regAddr;
    logic [15:0] data;
  } mmr_mgmt_s;

  typedef enum logic {MG_IDLE, MG_SHIFT} mmr_mgmt_e;
endpackage : mmr_pkg

// >>> sim/mmr_phy_model.sv
// phy partner: free running link clocks, rx nibbles, col/crs and mdio read answers
// assumes the bench sets the rx source and mdio has a pull-up
`timescale 1ns/10ps
`default_nettype none
module mmr_phy_model
  import mmr_pkg::*;
#(
  parameter logic [15:0] READ_VALUE = 16'hC3A5
) (
  // bench side
  input wire mmr_rx_s rxSrc,
  input wire logic colSrc,
  input wire logic crsSrc,
  // mii side
  input wire logic phyReceiveOutputEnable,
  input wire logic mdcPin,
  input wire logic mdioOe,
  input wire logic mdioOut,
  output logic rxClkPin,
  output logic txClkPin,
  output mmr_rx_s rxPins,
  output logic colPin,
  output logic crsPin,
  output logic mdioIn
);
  mmr_rx_s lastRx = '0;
  logic [4:0] cnt = '0;
  initial begin
    rxClkPin = 1'b0;
    #37;
    forever #200 rxClkPin = ~rxClkPin;
  end
  initial begin
    txClkPin = 1'b0;
    #113;
    forever #200 txClkPin = ~txClkPin;
  end
  // change on the falling edge, settled at the rising one
  always @(negedge rxClkPin) lastRx <= rxSrc;
  assign rxPins = phyReceiveOutputEnable ? lastRx : ~lastRx;
  assign colPin = colSrc;
  assign crsPin = crsSrc;
  always @(negedge mdcPin) begin
    #1;
    cnt <= mdioOe ? 5'h0 : cnt + 5'h1;
  end
  // turnaround: released bit, then zero, then data msb first
  // after the last data bit the line is released again and the pull-up shows
  assign mdioIn = mdioOe ? mdioOut : (cnt < 5'h2) ? 1'b1 :
    (cnt == 5'h2) ? 1'b0 : (cnt > 5'd18) ? 1'b1 : READ_VALUE[4'(5'd18 - cnt)];
endmodule : mmr_phy_model
`default_nettype wire

// >>> sim/mmr_mii_port_tb.sv
// self-checking bench for the mii port with boot rom pin sharing
// assumes the phy model supplies link clocks, rx pins and mdio answers
`timescale 1ns/10ps
`default_nettype none
module mmr_mii_port_tb;
  import mmr_pkg::*;
  localparam logic [15:0] READ_VALUE = 16'hC3A5;
  logic clk, rstn, externalPhySelect, forceSpeed, forcedSpeed100, autoNegDone;
  logic autoNegSpeed100, lineSpeed100, romAccess, colPin, crsPin, colSrc, crsSrc;
  logic rxClkPin, txClkPin, rxPinOe, phyReceiveOutputEnable, phyReceiveOutputEnableOe;
  logic txEnPin, txPinOe, mdcPin, mdcPinOe, mdioIn, mdioOut, mdioOe, rxStrobe;
  logic collision, carrierSense, txTaken, mgmtStart, mgmtBusy, mgmtDone, mdcPrev;
  logic [15:6] bootRomAddress;
  logic [3:0] txdPin;
  logic [15:0] mgmtReadData;
  logic [63:0] frm;
  mmr_rx_s rxSrc, rxPins, rxPinIn, rxPinOut, rxData;
  mmr_tx_s txData;
  mmr_mgmt_s mgmtReq;
  int n_errors = 0, n_checks = 0, perCnt = 0, minPer = 999;

  assign rxPinIn = rxPinOe ? rxPinOut : rxPins;
  mmr_mii_port dut (.clk, .rstn, .externalPhySelect, .forceSpeed, .forcedSpeed100,
    .autoNegDone, .autoNegSpeed100, .lineSpeed100, .romAccess, .bootRomAddress, .colPin,
    .crsPin, .rxClkPin, .txClkPin, .rxPinIn, .rxPinOut, .rxPinOe, .phyReceiveOutputEnable,
    .phyReceiveOutputEnableOe, .txdPin, .txEnPin, .txPinOe, .mdcPin, .mdcPinOe, .mdioIn,
    .mdioOut, .mdioOe, .rxData, .rxStrobe, .collision, .carrierSense, .txData, .txTaken,
    .mgmtStart, .mgmtReq, .mgmtBusy, .mgmtDone, .mgmtReadData);
  mmr_phy_model #(.READ_VALUE(READ_VALUE)) phy (.rxSrc, .colSrc, .crsSrc,
    .phyReceiveOutputEnable, .mdcPin, .mdioOe, .mdioOut, .rxClkPin, .txClkPin, .rxPins,
    .colPin, .crsPin, .mdioIn);

  always #25 clk = ~clk;
  always @(posedge mdcPin) frm <= {frm[62:0], mdioIn};
  // shortest mdc period in clk cycles
  always @(posedge clk) begin
    perCnt <= perCnt + 1;
    mdcPrev <= mdcPin;
    if (mdcPin && !mdcPrev) begin
      if (perCnt < minPer) minPer <= perCnt;
      perCnt <= 1;
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic waitfor(input int sel);
    for (int i = 0; i < 2000; i++) begin
      @(negedge clk);
      if ((sel == 0 && rxStrobe === 1'b1) || (sel == 1 && txTaken === 1'b1) ||
          (sel == 2 && mgmtDone === 1'b1)) return;
    end
    n_errors++;
    $display("ERROR wait %0d expected 1 seen timeout", sel);
    wrap_up();
  endtask : waitfor

  task automatic t_reset();
    @(negedge clk);
    chk("mdcPin", 0, mdcPin);
    chk("txEnPin", 0, txEnPin);
    chk("mdcPinOe", 0, mdcPinOe);
    chk("txPinOe", 0, txPinOe);
    chk("rxOeOe", 0, phyReceiveOutputEnableOe);
    @(posedge clk) rstn <= 1'b1;
    @(posedge clk) externalPhySelect <= 1'b1;
    @(negedge clk);
    chk("mdcPinOe", 1, mdcPinOe);
    chk("txPinOe", 1, txPinOe);
  endtask : t_reset

  task automatic t_rx(input mmr_rx_s v);
    @(posedge clk) rxSrc <= v;
    waitfor(0);
    waitfor(0);
    chk("rxData", v, rxData);
  endtask : t_rx

  task automatic t_tx(input logic [3:0] nib);
    @(posedge clk) txData <= '{valid: 1'b1, nibble: nib};
    waitfor(1);
    @(posedge clk) txData <= '{valid: 1'b0, nibble: 4'h0};
    @(negedge clk);
    chk("txdPin", nib, txdPin);
    chk("txEnPin", 1, txEnPin);
  endtask : t_tx

  task automatic t_tx_idle();
    repeat (12) @(negedge clk);
    chk("txEnPin", 0, txEnPin);
    chk("txdPin", 0, txdPin);
  endtask : t_tx_idle

  task automatic t_rom();
    int n = 0;
    @(posedge clk) begin
      romAccess <= 1'b1;
      bootRomAddress <= 10'h2B5;
      txData <= '{valid: 1'b1, nibble: 4'h9};
    end
    // a capture launched at the edge that starts the access may still show
    @(negedge clk);
    repeat (24) begin
      @(negedge clk);
      if (rxStrobe !== 1'b0 || txTaken !== 1'b0) n++;
    end
    chk("rxPinOut", 6'h35, rxPinOut);
    chk("rxPinOe", 1, rxPinOe);
    chk("mdcPinOe", 0, mdcPinOe);
    chk("txdRom", 4'hA, txdPin);
    chk("txEnRom", 0, txEnPin);
    chk("romCaptures", 0, n);
    chk("rxOutEnable", 0, phyReceiveOutputEnable);
    @(posedge clk) begin
      romAccess <= 1'b0;
      txData <= '{valid: 1'b0, nibble: 4'h0};
    end
    @(negedge clk);
    chk("rxOutEnable", 1, phyReceiveOutputEnable);
    chk("rxPinOe", 0, rxPinOe);
  endtask : t_rom

  task automatic t_speed();
    // {force, forced, done, negotiated, expected}; last row holds the old value
    logic [4:0] tab [4] = '{5'b11001, 5'b10110, 5'b00111, 5'b00001};
    foreach (tab[i]) begin
      @(posedge clk) {forceSpeed, forcedSpeed100, autoNegDone, autoNegSpeed100} <= tab[i][4:1];
      repeat (3) @(negedge clk);
      chk("lineSpeed100", tab[i][0], lineSpeed100);
    end
  endtask : t_speed

  task automatic t_colcrs();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {crsSrc, colSrc} <= 2'(i);
      repeat (6) @(negedge clk);
      chk("collision", i % 2, collision);
      chk("carrierSense", i / 2, carrierSense);
    end
  endtask : t_colcrs

  task automatic t_mgmt(input logic w, input logic [4:0] pa, ra, input logic [15:0] d);
    logic [63:0] expFrame;
    expFrame = {32'hFFFFFFFF, 2'b01, w ? 2'b01 : 2'b10, pa, ra, 2'b10, w ? d : READ_VALUE};
    @(posedge clk) begin
      mgmtStart <= 1'b1;
      mgmtReq <= '{write: w, phyAddr: pa, regAddr: ra, data: d};
    end
    @(posedge clk) mgmtStart <= 1'b0;
    @(negedge clk);
    chk("mgmtBusy", 1, mgmtBusy);
    chk("mdioOe", 1, mdioOe);
    waitfor(2);
    chk("mdioFrame", expFrame, frm);
    if (!w) chk("mgmtReadData", READ_VALUE, mgmtReadData);
  endtask : t_mgmt

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  initial begin
    {clk, rstn, externalPhySelect, forceSpeed, forcedSpeed100, autoNegDone} = '0;
    {autoNegSpeed100, romAccess, colSrc, crsSrc, mgmtStart} = '0;
    bootRomAddress = '0;
    rxSrc = '0;
    txData = '0;
    mgmtReq = '0;
    repeat (16) @(posedge clk);
    t_reset();
    t_rx('{dv: 1'b1, er: 1'b1, nibble: 4'hB});
    t_rx('{dv: 1'b0, er: 1'b0, nibble: 4'h4});
    t_tx(4'hC);
    t_tx(4'h3);
    t_tx_idle();
    t_rom();
    t_speed();
    t_colcrs();
    t_mgmt(1'b1, 5'h15, 5'h0A, 16'h1234);
    t_mgmt(1'b0, 5'h0B, 5'h13, 16'h0000);
    chk("mdcPeriodOk", 1, minPer >= 8);
    wrap_up();
  end
endmodule : mmr_mii_port_tb
`default_nettype wire
